// >>> rtl/phy_vendor_mgmt_regs.sv
// Vendor management registers 16 to 20 of the Fast Ethernet PHY
`include "phy_mgmt_consts.svh"

module phy_vendor_mgmt_regs #(
  parameter int CNT_WIDTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // Management register port
  input  wire logic [4:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [15:0]      reg_wdata,
  output logic      [15:0]      reg_rdata,
  output logic                  reg_rvalid,
  // PHY status
  input  wire logic             rx_sync,
  input  wire logic             pd_100,
  input  wire logic             pd_10,
  input  wire logic             pol_reversed,
  input  wire logic             speed_100,
  input  wire logic             full_duplex,
  // PHY events
  input  wire logic             false_carrier_evt,
  input  wire logic             disconnect_evt,
  // Status/control outputs
  output logic                  disconnect_en,
  output logic                  tx_flow_en,
  // Special control outputs
  output logic                  scrambler_bypass,
  output logic                  coder_bypass,
  output logic                  force_h_pattern,
  output logic                  force_34_pattern,
  output logic                  force_link_good,
  output logic                  tx_crs_disable,
  output logic                  dyn_pd_disable,
  output logic                  an_loopback,
  output logic                  mdi_tristate,
  output logic                  filter_bypass,
  output logic                  autopol_disable,
  output logic                  squelch_disable,
  output logic                  ext_squelch_en,
  output logic                  link_int_disable,
  output logic                  jabber_disable
);

  phy_mgmt_pkg::word_t sc_q;
  phy_mgmt_pkg::word_t sc_d;
  phy_mgmt_pkg::word_t sp_q;
  phy_mgmt_pkg::word_t sp_d;
  phy_mgmt_pkg::word_t rdata_q;
  phy_mgmt_pkg::word_t rdata_d;
  logic                rvalid_q;
  logic                rvalid_d;
  logic                rd_fc;
  logic                rd_disc;

  cnt_if #(.WIDTH(CNT_WIDTH)) fc_cnt ();
  cnt_if #(.WIDTH(CNT_WIDTH)) disc_cnt ();

  function automatic phy_mgmt_pkg::word_t status_word(input phy_mgmt_pkg::word_t ctl);
    phy_mgmt_pkg::word_t w;
    w = ctl & `SC_WR_MASK;
    w[`SC_RX_SYNC]  = rx_sync;
    w[`SC_PD_100]   = pd_100;
    w[`SC_PD_10]    = pd_10;
    w[`SC_POLARITY] = pol_reversed;
    w[`SC_SPEED]    = speed_100;
    w[`SC_DUPLEX]   = full_duplex;
    return w;
  endfunction

  // Register writes
  always_comb begin
    sc_d = (sc_q & `SC_WR_MASK) | (status_word(sc_q) & ~`SC_WR_MASK);
    sp_d = sp_q;
    if (reg_wr && reg_addr == `ADDR_STATUS_CTRL) begin
      sc_d = (reg_wdata & `SC_WR_MASK) | (sc_d & ~`SC_WR_MASK);
    end
    if (reg_wr && reg_addr == `ADDR_SPECIAL_CTRL) begin
      sp_d = reg_wdata;
    end
  end

  // Read-clear strobes for the counters
  assign rd_fc   = reg_rd && reg_addr == `ADDR_FALSE_CARRIER;
  assign rd_disc = reg_rd && reg_addr == `ADDR_DISCONNECT;

  assign fc_cnt.inc   = false_carrier_evt;
  assign fc_cnt.clr   = rd_fc;
  assign disc_cnt.inc = disconnect_evt;
  assign disc_cnt.clr = rd_disc;

  event_counter #(.WIDTH(CNT_WIDTH)) u_fc_cnt (
    .mclk (mclk),
    .rstn (rstn),
    .cnt  (fc_cnt.counter)
  );

  event_counter #(.WIDTH(CNT_WIDTH)) u_disc_cnt (
    .mclk (mclk),
    .rstn (rstn),
    .cnt  (disc_cnt.counter)
  );

  // Read data selection, unmapped addresses read zero
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_STATUS_CTRL:   rdata_d = sc_q;
        `ADDR_SPECIAL_CTRL:  rdata_d = sp_q;
        `ADDR_PHY_ADDRESS:   rdata_d = `PHY_ADDRESS_WORD;
        `ADDR_FALSE_CARRIER: rdata_d = 16'(fc_cnt.value);
        `ADDR_DISCONNECT:    rdata_d = 16'(disc_cnt.value);
        default:             rdata_d = 16'h_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sc_q     <= `SC_RESET;
      sp_q     <= `SP_RESET;
      rdata_q  <= 16'h_0000;
      rvalid_q <= 1'b0;
    end else begin
      sc_q     <= sc_d;
      sp_q     <= sp_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  assign disconnect_en    = sc_q[`SC_DISC_EN];
  assign tx_flow_en       = sc_q[`SC_TX_FLOW_EN];
  assign scrambler_bypass = sp_q[`SP_SCR_BYPASS];
  assign coder_bypass     = sp_q[`SP_CODER_BYPASS];
  assign force_h_pattern  = sp_q[`SP_FORCE_H];
  assign force_34_pattern = sp_q[`SP_FORCE_34];
  assign force_link_good  = sp_q[`SP_LINK_GOOD];
  assign tx_crs_disable   = sp_q[`SP_TX_CRS_DIS];
  assign dyn_pd_disable   = sp_q[`SP_DYN_PD_DIS];
  assign an_loopback      = sp_q[`SP_AN_LOOPBACK];
  assign mdi_tristate     = sp_q[`SP_MDI_TRISTATE];
  assign filter_bypass    = sp_q[`SP_FILTER_BYPASS];
  assign autopol_disable  = sp_q[`SP_AUTOPOL_DIS];
  assign squelch_disable  = sp_q[`SP_SQUELCH_DIS];
  assign ext_squelch_en   = sp_q[`SP_EXT_SQUELCH];
  assign link_int_disable = sp_q[`SP_LINK_INT_DIS];
  assign jabber_disable   = sp_q[`SP_JABBER_DIS];

  // Checks

  a_disc_en_write: assert property (@(posedge mclk) disable iff (!rstn)
    (reg_wr && reg_addr == `ADDR_STATUS_CTRL) |=> (disconnect_en == $past(reg_wdata[13])))
    else $error("disconnect enable not written");

  a_flow_en_write: assert property (@(posedge mclk) disable iff (!rstn)
    (reg_wr && reg_addr == `ADDR_STATUS_CTRL) |=> (tx_flow_en == $past(reg_wdata[12])))
    else $error("flow control enable not written");

  a_sync_readback: assert property (@(posedge mclk) disable iff (!rstn)
    (reg_rd && reg_addr == `ADDR_STATUS_CTRL && $past(rstn))
    |=> (reg_rdata[11] == $past(rx_sync, 2)))
    else $error("sync bit does not follow de-serializer");

  a_pd_readback: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(rstn) ##0 (reg_rd && reg_addr == `ADDR_STATUS_CTRL) |=> (reg_rdata[10:9] == 2'b11))
    else $error("power-down bits not set after reset");

  a_pol_readback: assert property (@(posedge mclk) disable iff (!rstn)
    (pol_reversed ##1 (reg_rd && reg_addr == `ADDR_STATUS_CTRL)) |=> reg_rdata[8] && reg_rvalid)
    else $error("polarity bit wrong");

  a_speed_duplex: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 (reg_rd && reg_addr == `ADDR_STATUS_CTRL)
    |=> (reg_rdata[1:0] == {$past(speed_100, 2), $past(full_duplex, 2)}))
    else $error("speed or duplex bit wrong");

  a_special_write: assert property (@(posedge mclk)
    disable iff (!rstn)
    (reg_wr && reg_addr == `ADDR_SPECIAL_CTRL)
    |=> ({scrambler_bypass, coder_bypass, force_h_pattern, force_34_pattern, force_link_good,
          tx_crs_disable, dyn_pd_disable, an_loopback, mdi_tristate, filter_bypass, autopol_disable,
          squelch_disable, ext_squelch_en, link_int_disable, jabber_disable}
         == {$past(reg_wdata[15:11]), $past(reg_wdata[9:0])}))
    else $error("special control outputs do not follow write");

  a_addr_const: assert property (@(posedge mclk) disable iff (!rstn)
    (reg_rd && reg_addr == `ADDR_PHY_ADDRESS) |=> (reg_rvalid && reg_rdata == 16'h_0001))
    else $error("address register not constant");

  a_count_readout: assert property (@(posedge mclk) disable iff (!rstn)
    (reg_rd && reg_addr == `ADDR_DISCONNECT) |=> (reg_rdata == 16'($past(disc_cnt.value))))
    else $error("disconnect count read wrong");

  a_fc_readout: assert property (@(posedge mclk) disable iff (!rstn)
    (reg_rd && reg_addr == `ADDR_FALSE_CARRIER) ##1 (reg_rd && reg_addr == `ADDR_FALSE_CARRIER)
    |=> (reg_rdata == 16'($past(fc_cnt.inc, 2))))
    else $error("false carrier count not cleared by read");

endmodule // phy_vendor_mgmt_regs

// >>> include/phy_mgmt_consts.svh
// Offsets, bit positions and reset values of the vendor management registers
`ifndef PHY_MGMT_CONSTS_SVH
`define PHY_MGMT_CONSTS_SVH

`define ADDR_STATUS_CTRL   5'h10
`define ADDR_SPECIAL_CTRL  5'h11
`define ADDR_PHY_ADDRESS   5'h12
`define ADDR_FALSE_CARRIER 5'h13
`define ADDR_DISCONNECT    5'h14

`define SC_RSVD_HI        15
`define SC_RSVD_LO        14
`define SC_DISC_EN        13
`define SC_TX_FLOW_EN     12
`define SC_RX_SYNC        11
`define SC_PD_100         10
`define SC_PD_10          9
`define SC_POLARITY       8
`define SC_SPEED          1
`define SC_DUPLEX         0
`define SC_WR_MASK        16'h_F000
`define SC_RESET          16'h_0600

`define SP_SCR_BYPASS     15
`define SP_CODER_BYPASS   14
`define SP_FORCE_H        13
`define SP_FORCE_34       12
`define SP_LINK_GOOD      11
`define SP_TX_CRS_DIS     9
`define SP_DYN_PD_DIS     8
`define SP_AN_LOOPBACK    7
`define SP_MDI_TRISTATE   6
`define SP_FILTER_BYPASS  5
`define SP_AUTOPOL_DIS    4
`define SP_SQUELCH_DIS    3
`define SP_EXT_SQUELCH    2
`define SP_LINK_INT_DIS   1
`define SP_JABBER_DIS     0
`define SP_RESET          16'h_0000

`define PHY_ADDRESS_WORD  16'h_0001

`endif

// >>> include/phy_mgmt_pkg.sv
// Types shared by the management register bank
package phy_mgmt_pkg;
  typedef logic [15:0] word_t;
  typedef logic [4:0]  reg_addr_t;
endpackage

// >>> include/cnt_if.sv
// Event counter connection: event and read-clear in, count out
interface cnt_if #(parameter int WIDTH = 16);
  logic             inc;
  logic             clr;
  logic [WIDTH-1:0] value;

  modport counter (input inc, input clr, output value);
  modport owner   (output inc, output clr, input value);
endinterface

// >>> rtl/event_counter.sv
// Saturating event counter that clears when read
module event_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Counter port
  cnt_if.counter   cnt
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             full;

  assign full      = &cnt_q;
  assign cnt.value = cnt_q;

  // An event in the clearing cycle counts as the first of the new run
  always_comb begin
    cnt_d = cnt_q;
    if (cnt.clr) begin
      cnt_d = '0;
    end
    if (cnt.inc) begin
      if (cnt.clr) begin
        cnt_d = {{(WIDTH-1){1'b0}}, 1'b1};
      end else if (!full) begin
        cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  a_cnt_saturate: assert property (@(posedge mclk) disable iff (!rstn)
    (full && !cnt.clr) |=> (&cnt_q)) else $error("counter left its maximum");

  a_cnt_read_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (cnt.clr && !cnt.inc) |=> (cnt_q == '0)) else $error("counter not cleared by read");

  a_cnt_step_one: assert property (@(posedge mclk) disable iff (!rstn)
    (cnt.inc && !cnt.clr && !full) |=> (cnt_q == $past(cnt_q) + 1'b1)) else $error("counter step wrong");

endmodule // event_counter

// >>> tb/mgmt_station.sv
// Station management model that issues register reads and writes
module mgmt_station (
  // Clock
  input  wire logic        mclk,
  // Request side
  output logic      [4:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  // Answer side
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h_0000;
  end

  // Called just after a falling edge; the rising edge between takes it
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
    @(negedge mclk);
  endtask

  // Read with a bounded wait for the valid pulse
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    n        = 0;
    d        = 'x;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd   = 1'b0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    if (reg_rvalid === 1'b1) d = reg_rdata;
    @(negedge mclk);
  endtask

  // Two reads of one address on back-to-back edges, strobe held between them
  task automatic rd2(input logic [4:0] a, output logic [15:0] d0, output logic [15:0] d1);
    d0       = 'x;
    d1       = 'x;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    if (reg_rvalid === 1'b1) d0 = reg_rdata;
    @(negedge mclk);
    reg_rd   = 1'b0;
    if (reg_rvalid === 1'b1) d1 = reg_rdata;
    @(negedge mclk);
  endtask
endmodule // mgmt_station

// >>> tb/phy_vendor_mgmt_regs_bench.sv
// Self-checking bench for the vendor management register bank
module phy_vendor_mgmt_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CW = 4;

  logic        mclk, rstn, reg_wr, reg_rd, reg_rvalid, fc_evt, dc_evt, de, tf;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, ctl, v, w;
  logic [5:0]  st;
  int          n_fail, checks;
  int          cycles = 0;

  mgmt_station station_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  phy_vendor_mgmt_regs #(.CNT_WIDTH(CW)) dut_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .full_duplex(st[0]), .speed_100(st[1]), .pol_reversed(st[2]),
    .pd_10(st[3]), .pd_100(st[4]), .rx_sync(st[5]), .false_carrier_evt(fc_evt),
    .disconnect_evt(dc_evt), .disconnect_en(de), .tx_flow_en(tf),
    .scrambler_bypass(ctl[15]), .coder_bypass(ctl[14]), .force_h_pattern(ctl[13]),
    .force_34_pattern(ctl[12]), .force_link_good(ctl[11]), .tx_crs_disable(ctl[9]),
    .dyn_pd_disable(ctl[8]), .an_loopback(ctl[7]), .mdi_tristate(ctl[6]),
    .filter_bypass(ctl[5]), .autopol_disable(ctl[4]), .squelch_disable(ctl[3]),
    .ext_squelch_en(ctl[2]), .link_int_disable(ctl[1]), .jabber_disable(ctl[0]));
  assign ctl[10] = 1'b0;

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic t_reset();
    station_u.rd(5'h10, v); cmp(v, 16'h_0600);
    station_u.rd(5'h11, v); cmp(v, 16'h_0000);
    station_u.rd(5'h12, v); cmp(v, 16'h_0001);
    station_u.rd(5'h13, v); cmp(v, 16'h_0000);
    station_u.rd(5'h14, v); cmp(v, 16'h_0000);
    cmp(ctl, 16'h_0000);
    cmp(16'({de, tf}), 16'h_0000);
    $display("test reset done");
  endtask

  task automatic t_status();
    int pos[6] = '{0, 1, 8, 9, 10, 11};
    for (int i = 0; i < 6; i++) begin
      st = 6'h01 << i;
      @(negedge mclk);
      station_u.rd(5'h10, v); cmp(v, 16'h_0001 << pos[i]);
    end
    st = 6'h00;
    @(negedge mclk);
    $display("test status done");
  endtask

  task automatic t_ctl10();
    station_u.wr(5'h10, 16'h_FFFF);
    cmp(16'({de, tf}), 16'h_0003);
    station_u.rd(5'h10, v); cmp(v, 16'h_F000);
    station_u.wr(5'h10, 16'h_1000);
    cmp(16'({de, tf}), 16'h_0001);
    $display("test status control done");
  endtask

  task automatic t_special();
    for (int i = 0; i < 16; i++) begin
      station_u.wr(5'h11, 16'h_0001 << i);
      cmp(ctl, (16'h_0001 << i) & 16'h_FBFF);
      station_u.rd(5'h11, v); cmp(v, 16'h_0001 << i);
    end
    station_u.wr(5'h11, 16'h_0000);
    cmp(ctl, 16'h_0000);
    $display("test special control done");
  endtask

  task automatic t_readonly();
    station_u.wr(5'h12, 16'h_FFFF);
    station_u.wr(5'h1F, 16'h_FFFF);
    station_u.rd(5'h12, v); cmp(v, 16'h_0001);
    station_u.rd(5'h1F, v); cmp(v, 16'h_0000);
    $display("test read only done");
  endtask

  task automatic t_counters();
    fc_evt = 1'b1;
    dc_evt = 1'b1;
    repeat (3) @(negedge mclk);
    fc_evt = 1'b0;
    dc_evt = 1'b0;
    station_u.rd(5'h13, v); cmp(v, 16'h_0003);
    station_u.rd(5'h14, v); cmp(v, 16'h_0003);
    station_u.rd(5'h13, v); cmp(v, 16'h_0000);
    fc_evt = 1'b1;
    dc_evt = 1'b1;
    repeat (20) @(negedge mclk);
    fc_evt = 1'b0;
    fork
      station_u.rd(5'h14, v);
      begin
        @(negedge mclk);
        dc_evt = 1'b0;
      end
    join
    cmp(v, 16'h_000F);
    station_u.rd(5'h14, v); cmp(v, 16'h_0001);
    station_u.rd2(5'h13, v, w);
    cmp(v, 16'h_000F);
    cmp(w, 16'h_0000);
    $display("test counters done");
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    n_fail = 0;
    checks = 0;
    rstn   = 1'b0;
    fc_evt = 1'b0;
    dc_evt = 1'b0;
    st     = 6'h00;
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    t_reset();
    t_status();
    t_ctl10();
    t_special();
    t_readonly();
    t_counters();
    wrap_up();
  end
endmodule // phy_vendor_mgmt_regs_bench
